/* File: src/flash_prog_pkg.sv */
package flash_prog_pkg;

  localparam logic [7:0]  UNLOCK_KEY      = 8'ha5;
  localparam logic [7:0]  RELOCK_VALUE    = 8'h00;
  localparam logic [7:0]  UNLOCK_RESET    = 8'h00;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [7:0]  SECT_RESET      = 8'h00;
  localparam logic [7:0]  OPT_RESET       = 8'hff;
  localparam logic [15:0] OPTION_ADDR     = 16'h003e;

  // Control codes: upper seven bits select the operation, bit 0 starts an erase.
  localparam logic [6:0]  CODE_ERASE      = 7'h50;
  localparam logic [6:0]  CODE_PROGRAM    = 7'h28;
  localparam int          START_BIT       = 0;
  localparam logic [7:0]  CTRL_ERASE_GO   = 8'ha1;
  localparam logic [7:0]  CTRL_PROGRAM    = 8'h50;

  // Option byte fields.
  localparam int          PROT_OFF_BIT    = 2;
  localparam int          VEC_FIELD_LSB   = 5;
  localparam int          VEC_OFF_BIT     = 7;

  // Sector geometry.
  localparam int          SECTOR_BYTES    = 128;
  localparam int          SECTOR_SHIFT    = 7;
  localparam logic [15:0] PROT_BASE       = 16'h0100;
  localparam logic [15:0] PROT_END_0      = 16'h01ff;
  localparam logic [15:0] PROT_END_1      = 16'h02ff;
  localparam logic [15:0] PROT_END_2      = 16'h04ff;
  localparam logic [15:0] PROT_END_3      = 16'h08ff;
  localparam logic [15:0] VEC_PLAIN       = 16'h0100;
  localparam logic [15:0] VEC_0           = 16'h0200;
  localparam logic [15:0] VEC_1           = 16'h0300;
  localparam logic [15:0] VEC_2           = 16'h0500;
  localparam logic [15:0] VEC_3           = 16'h0900;

  // Timing at a 100 ns clock.
  localparam int          CLK_PERIOD_NS   = 100;
  localparam int          ERASE_TIME_US   = 4000;
  localparam int          ERASE_CYCLES    = (ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          PROG_TIME_US    = 25;
  localparam int          PROG_CYCLES     = (PROG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    REG_CTRL   = 3'h0,
    REG_UNLOCK = 3'h1,
    REG_SECT_H = 3'h2,
    REG_SECT_L = 3'h3,
    REG_STATUS = 3'h4
  } reg_sel_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'h0,
    ST_ERASE   = 2'h1,
    ST_PROGRAM = 2'h2
  } flash_state_t;

  // Host register map on Avalon-MM (word addresses).
  localparam logic [2:0]  HREG_CMD        = 3'h0;
  localparam logic [2:0]  HREG_ADDR       = 3'h1;
  localparam logic [2:0]  HREG_DATA       = 3'h2;
  localparam logic [2:0]  HREG_STATUS     = 3'h3;
  localparam logic [2:0]  HREG_RDATA      = 3'h4;
  localparam logic [1:0]  CMD_REG_WRITE   = 2'h0;
  localparam logic [1:0]  CMD_REG_READ    = 2'h1;
  localparam logic [1:0]  CMD_STORE       = 2'h2;

endpackage : flash_prog_pkg

/* File: src/flash_cpu_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface flash_cpu_if;
  logic        regWrite;
  logic        regRead;
  logic [2:0]  regSel;
  logic [7:0]  regWdata;
  logic [7:0]  regRdata;
  logic        store;
  logic [15:0] storeAddr;
  logic [7:0]  storeData;
  logic        cpuStall;

  modport device (
    input  regWrite, regRead, regSel, regWdata, store, storeAddr, storeData,
    output regRdata, cpuStall
  );
  modport cpu (
    output regWrite, regRead, regSel, regWdata, store, storeAddr, storeData,
    input  regRdata, cpuStall
  );
endinterface : flash_cpu_if
`default_nettype wire

/* File: src/flash_user_program_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Boot sector rejects user erase and program.
// - Protection only while enable bit is zero.
// - Option bits 2:0 select protected size.
// - Tool mode may erase and program boot sector.
// - Option bits 7:5 select reset vector.
// - Vector field is used only while protection is on (bit 2 zero).
// - User erase covers whole 128-byte sectors.
// - Software erases sector before programming it.
// - Erase stays active at least 4 ms.
// - No sector erase in tool modes.
// - Erase sequence: key, sector, code, relock.
// - Key written before sector and erase start.
// - Start bit clears when erase completes.
// - Erase without key leaves start bit set.
// - Each store programs one byte.
// - Program sequence: key, code, sector, stores, relock.
// - Program mode ignores the start bit.
// - Unlock resets zero, enables only on key.
// - CPU stalls for the whole erase.
// - Sector low bits 6:0 are ignored.
module flash_user_program_ctrl #(
  parameter int ADDR_W      = 13,
  parameter int ERASE_COUNT = flash_prog_pkg::ERASE_CYCLES,
  parameter int PROG_COUNT  = flash_prog_pkg::PROG_CYCLES
) (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  flash_cpu_if.device            cpu,
  input  wire logic [7:0]        optionByte,
  input  wire logic              toolMode,
  input  wire logic              toolWrite,
  input  wire logic              toolErase,
  input  wire logic [15:0]       toolAddr,
  input  wire logic [7:0]        toolData,
  input  wire logic [15:0]       readAddr,
  output logic      [7:0]        readData,
  output logic      [15:0]       resetVector,
  output logic                   busy,
  output logic                   rejected
);

  localparam int SECTORS = (1 << ADDR_W) / flash_prog_pkg::SECTOR_BYTES;

  logic [7:0]  mem [0:(1 << ADDR_W) - 1];
  logic [7:0]  ctrl_q;
  logic [7:0]  unlock_q;
  logic [7:0]  sectH_q;
  logic [7:0]  sectL_q;
  logic [31:0] count_q;
  logic [15:0] eraseBase_q;
  logic [15:0] resetVector_q;
  logic        rejected_q;
  logic        busy_q;
  logic [7:0]  readData_q;
  logic [7:0]  regRdata_q;
  flash_prog_pkg::flash_state_t state_q;

  logic        unlocked;
  logic        protOn;
  logic [15:0] protEnd;
  logic [15:0] sectBase;
  logic        eraseGo;
  logic        storeOk;
  logic        storeSeen;

  assign unlocked = (unlock_q == flash_prog_pkg::UNLOCK_KEY);
  assign sectBase = {sectH_q, sectL_q[7], 7'h00};

  // Protected window from option bits 2:0; bit 2 set disables it.
  always_comb begin
    protOn  = !optionByte[flash_prog_pkg::PROT_OFF_BIT];
    unique case (optionByte[1:0])
      2'h0: protEnd = flash_prog_pkg::PROT_END_0;
      2'h1: protEnd = flash_prog_pkg::PROT_END_1;
      2'h2: protEnd = flash_prog_pkg::PROT_END_2;
      2'h3: protEnd = flash_prog_pkg::PROT_END_3;
    endcase
  end

  function automatic logic inProt(input logic [15:0] a, input logic on, input logic [15:0] last);
    inProt = on && (a >= flash_prog_pkg::PROT_BASE) && (a <= last);
  endfunction : inProt

  assign eraseGo = (state_q == flash_prog_pkg::ST_IDLE) && ctrl_q[flash_prog_pkg::START_BIT]
                   && (ctrl_q[7:1] == flash_prog_pkg::CODE_ERASE) && unlocked && !toolMode
                   && !inProt(sectBase, protOn, protEnd);
  assign storeSeen = cpu.store && (state_q == flash_prog_pkg::ST_IDLE) && !toolMode;
  assign storeOk = storeSeen && unlocked && (ctrl_q[7:1] == flash_prog_pkg::CODE_PROGRAM)
                   && (cpu.storeAddr[15:7] == sectBase[15:7])
                   && (cpu.storeAddr[15:ADDR_W] == '0)
                   && !inProt(cpu.storeAddr, protOn, protEnd);

  // Register writes from the CPU and hardware clear of the start bit.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl_q   <= flash_prog_pkg::CTRL_RESET;
      unlock_q <= flash_prog_pkg::UNLOCK_RESET;
      sectH_q  <= flash_prog_pkg::SECT_RESET;
      sectL_q  <= flash_prog_pkg::SECT_RESET;
    end else begin
      if (cpu.regWrite && !busy_q) begin
        unique case (cpu.regSel)
          flash_prog_pkg::REG_CTRL:   ctrl_q   <= cpu.regWdata;
          flash_prog_pkg::REG_UNLOCK: unlock_q <= cpu.regWdata;
          flash_prog_pkg::REG_SECT_H: sectH_q  <= cpu.regWdata;
          flash_prog_pkg::REG_SECT_L: sectL_q  <= cpu.regWdata;
          default: ;
        endcase
      end
      if (state_q == flash_prog_pkg::ST_ERASE && count_q == 32'd1) begin
        ctrl_q[flash_prog_pkg::START_BIT] <= 1'b0;
      end
    end
  end

  // Operation sequencer and stall.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q     <= flash_prog_pkg::ST_IDLE;
      count_q     <= '0;
      busy_q      <= 1'b0;
      rejected_q  <= 1'b0;
      eraseBase_q <= '0;
    end else begin
      rejected_q <= storeSeen && !storeOk;
      unique case (state_q)
        flash_prog_pkg::ST_IDLE: begin
          if (eraseGo) begin
            state_q     <= flash_prog_pkg::ST_ERASE;
            count_q     <= ERASE_COUNT;
            eraseBase_q <= sectBase;
            busy_q      <= 1'b1;
          end else if (storeOk) begin
            state_q <= flash_prog_pkg::ST_PROGRAM;
            count_q <= PROG_COUNT;
            busy_q  <= 1'b1;
          end
        end
        default: begin
          count_q <= count_q - 32'd1;
          if (count_q == 32'd1) begin
            state_q <= flash_prog_pkg::ST_IDLE;
            busy_q  <= 1'b0;
          end
        end
      endcase
    end
  end

  // Array contents: whole-sector erase, single-byte program, tool access.
  always_ff @(posedge sys_clk) begin
    if (state_q == flash_prog_pkg::ST_ERASE && count_q == 32'd1) begin
      for (int i = 0; i < flash_prog_pkg::SECTOR_BYTES; i++) begin
        mem[ADDR_W'(eraseBase_q) + ADDR_W'(i)] <= 8'hff;
      end
    end else if (storeOk) begin
      mem[cpu.storeAddr[ADDR_W-1:0]] <= mem[cpu.storeAddr[ADDR_W-1:0]] & cpu.storeData;
    end else if (toolMode && toolErase) begin
      for (int i = 0; i < SECTORS * flash_prog_pkg::SECTOR_BYTES; i++) begin
        mem[i] <= 8'hff;
      end
    end else if (toolMode && toolWrite) begin
      mem[toolAddr[ADDR_W-1:0]] <= toolData;
    end
  end

  // Reset vector, latched from the option byte.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      resetVector_q <= flash_prog_pkg::VEC_PLAIN;
    end else if (!protOn || optionByte[flash_prog_pkg::VEC_OFF_BIT]) begin
      resetVector_q <= flash_prog_pkg::VEC_PLAIN;
    end else begin
      unique case (optionByte[6:5])
        2'h0: resetVector_q <= flash_prog_pkg::VEC_0;
        2'h1: resetVector_q <= flash_prog_pkg::VEC_1;
        2'h2: resetVector_q <= flash_prog_pkg::VEC_2;
        2'h3: resetVector_q <= flash_prog_pkg::VEC_3;
      endcase
    end
  end

  // Read path for registers and array.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      regRdata_q <= '0;
      readData_q <= '0;
    end else begin
      readData_q <= mem[readAddr[ADDR_W-1:0]];
      unique case (cpu.regSel)
        flash_prog_pkg::REG_CTRL:   regRdata_q <= ctrl_q;
        flash_prog_pkg::REG_UNLOCK: regRdata_q <= unlock_q;
        flash_prog_pkg::REG_SECT_H: regRdata_q <= sectH_q;
        flash_prog_pkg::REG_SECT_L: regRdata_q <= sectL_q;
        flash_prog_pkg::REG_STATUS: regRdata_q <= {5'h00, rejected_q, state_q == flash_prog_pkg::ST_ERASE, busy_q};
        default:                    regRdata_q <= '0;
      endcase
    end
  end

  assign cpu.regRdata = regRdata_q;
  assign cpu.cpuStall = busy_q;
  assign readData     = readData_q;
  assign resetVector  = resetVector_q;
  assign busy         = busy_q;
  assign rejected     = rejected_q;

endmodule : flash_user_program_ctrl
`default_nettype wire

/* File: src/flash_cpu_master.sv */
`timescale 1ns/100ps
`default_nettype none
// CPU-side end: software orders arrive over Avalon-MM and become one-cycle strobes.
module flash_cpu_master (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  flash_cpu_if.cpu         link,
  input  wire logic [2:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest
);

  logic [15:0] addr_q;
  logic [7:0]  data_q;
  logic [7:0]  rdata_q;
  logic [31:0] readdata_q;
  logic        regWrite_q;
  logic        regRead_q;
  logic        store_q;
  logic [2:0]  regSel_q;
  logic        pend_q;
  logic        wait_q;
  logic        recent_q;

  // A write to the command word fires one strobe; it waits while the device stalls.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      addr_q     <= '0;
      data_q     <= '0;
      regSel_q   <= '0;
      regWrite_q <= 1'b0;
      regRead_q  <= 1'b0;
      store_q    <= 1'b0;
      pend_q     <= 1'b0;
      rdata_q    <= '0;
    end else begin
      regWrite_q <= 1'b0;
      regRead_q  <= 1'b0;
      store_q    <= 1'b0;
      if (regRead_q) begin
        pend_q <= 1'b1;
      end else if (pend_q) begin
        rdata_q <= link.regRdata;
        pend_q  <= 1'b0;
      end
      if (write && !wait_q && !link.cpuStall) begin
        unique case (address)
          flash_prog_pkg::HREG_ADDR: addr_q <= writedata[15:0];
          flash_prog_pkg::HREG_DATA: data_q <= writedata[7:0];
          flash_prog_pkg::HREG_CMD: begin
            regSel_q   <= writedata[10:8];
            regWrite_q <= writedata[1:0] == flash_prog_pkg::CMD_REG_WRITE;
            regRead_q  <= writedata[1:0] == flash_prog_pkg::CMD_REG_READ;
            store_q    <= writedata[1:0] == flash_prog_pkg::CMD_STORE;
          end
          default: ;
        endcase
      end
    end
  end

  // Answers take one wait cycle: waitrequest drops on the first edge that sees the request.
  // A strobe holds off the next answer until the device has had time to raise its stall.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wait_q     <= 1'b1;
      recent_q   <= 1'b0;
      readdata_q <= '0;
    end else begin
      recent_q <= regWrite_q || store_q;
      wait_q   <= !(read || write) || !wait_q || link.cpuStall || pend_q || regRead_q
                  || regWrite_q || store_q || recent_q;
      unique case (address)
        flash_prog_pkg::HREG_ADDR:   readdata_q <= {16'h0000, addr_q};
        flash_prog_pkg::HREG_DATA:   readdata_q <= {24'h000000, data_q};
        flash_prog_pkg::HREG_STATUS: readdata_q <= {30'h00000000, pend_q | regRead_q, link.cpuStall};
        flash_prog_pkg::HREG_RDATA:  readdata_q <= {24'h000000, rdata_q};
        default:                     readdata_q <= '0;
      endcase
    end
  end

  assign link.regWrite  = regWrite_q;
  assign link.regRead   = regRead_q;
  assign link.regSel    = regSel_q;
  assign link.regWdata  = data_q;
  assign link.store     = store_q;
  assign link.storeAddr = addr_q;
  assign link.storeData = data_q;
  assign readdata       = readdata_q;
  assign waitrequest    = wait_q;

endmodule : flash_cpu_master
`default_nettype wire

/* File: bench/flash_link_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module flash_link_monitor #(
  parameter int ERASE_COUNT = 12
) (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [2:0]  regSel,
  input wire logic [7:0]  regWdata,
  input wire logic [7:0]  regRdata,
  input wire logic        store,
  input wire logic [15:0] storeAddr,
  input wire logic [7:0]  storeData,
  input wire logic        cpuStall
);
  logic [7:0] keyQ;
  logic [7:0] sectHighQ;
  int         eraseCnt;
  logic       ctrlGo;
  logic       eraseGo;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Sectors below 0900h are left out because they may be protected or written in tool mode.
  assign ctrlGo  = regWrite && !cpuStall && regSel == 3'h0 && regWdata == 8'ha1;
  assign eraseGo = ctrlGo && keyQ == 8'ha5 && sectHighQ >= 8'h09;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      keyQ <= 8'h00;
    end else if (regWrite && !cpuStall && regSel == 3'h1) begin
      keyQ <= regWdata;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sectHighQ <= 8'h00;
    end else if (regWrite && !cpuStall && regSel == 3'h2) begin
      sectHighQ <= regWdata;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      eraseCnt <= 0;
    end else if (eraseGo) begin
      eraseCnt <= 1;
    end else if (eraseCnt != 0 && eraseCnt < ERASE_COUNT + 8) begin
      eraseCnt <= eraseCnt + 1;
    end else begin
      eraseCnt <= 0;
    end
  end
  a_erase_starts: assert property (eraseGo |-> ##[1:3] cpuStall)
    else $error("erase did not stall the cpu");
  a_erase_holds: assert property (eraseCnt >= 3 && eraseCnt <= ERASE_COUNT |-> cpuStall)
    else $error("stall ended before the erase time");
  a_erase_ends: assert property (eraseCnt == ERASE_COUNT + 6 |-> !cpuStall)
    else $error("stall not released after erase");
  a_erase_blocks: assert property (eraseCnt >= 2 && eraseCnt <= ERASE_COUNT |-> !regWrite && !store)
    else $error("cpu request during erase");
  a_nokey_idle: assert property (ctrlGo && keyQ != 8'ha5 |=> !cpuStall [*2])
    else $error("erase started without key");
  a_reset_quiet: assert property ($fell(reset) |-> !cpuStall && !regWrite && !regRead && !store)
    else $error("activity right after reset");
  a_write_pulse: assert property (regWrite |=> !regWrite)
    else $error("register write longer than one cycle");
  a_store_pulse: assert property (store |=> !store [*2])
    else $error("store strobe repeated");
  c_erase: cover property (eraseGo);
  c_nokey: cover property (ctrlGo && keyQ != 8'ha5);
  c_store: cover property (store ##1 !store);
  c_reg_read: cover property (regRead ##1 regRdata != 8'h00);
  c_store_edge: cover property (store && storeAddr[6:0] == 7'h7f && storeData != 8'hff);
endmodule : flash_link_monitor
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; $display("mismatch %0t got %h want %h", $time, a, e); end end
module testbench;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic [2:0]  address = 3'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [7:0]  optionByte = 8'hff;
  logic        toolMode = 1'b0;
  logic        toolWrite = 1'b0;
  logic        toolErase = 1'b0;
  logic [15:0] toolAddr = 16'h0;
  logic [7:0]  toolData = 8'h0;
  logic [15:0] readAddr = 16'h0;
  logic [7:0]  readData;
  logic [15:0] resetVector;
  logic        busy;
  logic        rejected;
  logic [31:0] seed = 32'h09921da6;
  logic [7:0]  d;
  logic [7:0]  old;
  logic [15:0] a;
  int          err_count = 0;
  int          checks = 0;
  int          cycles = 0;
  int          rejCnt = 0;
  int          rc;
  flash_cpu_if cpuLink();
  flash_cpu_master i_flash_cpu_master(.sys_clk(sys_clk), .reset(reset), .link(cpuLink), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
  flash_user_program_ctrl #(.ERASE_COUNT(12), .PROG_COUNT(6)) i_flash_user_program_ctrl(.sys_clk(sys_clk),
    .reset(reset), .cpu(cpuLink), .optionByte(optionByte), .toolMode(toolMode), .toolWrite(toolWrite),
    .toolErase(toolErase), .toolAddr(toolAddr), .toolData(toolData), .readAddr(readAddr), .readData(readData),
    .resetVector(resetVector), .busy(busy), .rejected(rejected));
  flash_link_monitor #(.ERASE_COUNT(12)) i_flash_link_monitor(.sys_clk(sys_clk), .reset(reset),
    .regWrite(cpuLink.regWrite), .regRead(cpuLink.regRead), .regSel(cpuLink.regSel),
    .regWdata(cpuLink.regWdata), .regRdata(cpuLink.regRdata), .store(cpuLink.store),
    .storeAddr(cpuLink.storeAddr), .storeData(cpuLink.storeData), .cpuStall(cpuLink.cpuStall));
  always #50 sys_clk = ~sys_clk;
  task close_out;
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  always @(posedge sys_clk) begin
    cycles++;
    if (rejected === 1'b1) rejCnt++;
    if (cycles == 30000) begin
      err_count++;
      close_out();
    end
  end
  function automatic logic [15:0] vecExp(input logic [7:0] o);
    if (o[2] || o[7]) return 16'h0100;
    return 16'h0100 + (16'h0100 << o[6:5]);
  endfunction : vecExp
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xorshift
  task step;
    seed = xorshift(seed);
  endtask : step
  task av(input logic wr, input logic [2:0] ad, input logic [31:0] wd, output logic [31:0] q);
    @(posedge sys_clk);
    address <= ad;
    writedata <= wd;
    write <= wr;
    read <= !wr;
    do @(posedge sys_clk); while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : av
  task idle;
    repeat (3) @(negedge sys_clk);
    while (busy !== 1'b0) @(negedge sys_clk);
  endtask : idle
  task wreg(input logic [2:0] s, input logic [7:0] v);
    logic [31:0] q;
    av(1'b1, 3'h2, {24'h0, v}, q);
    av(1'b1, 3'h0, {21'h0, s, 8'h00}, q);
  endtask : wreg
  task rreg(input logic [2:0] s, output logic [7:0] v);
    logic [31:0] q;
    av(1'b1, 3'h0, {21'h0, s, 8'h01}, q);
    av(1'b0, 3'h4, 32'h0, q);
    v = q[7:0];
  endtask : rreg
  task prog(input logic [15:0] ad, input logic [7:0] v);
    logic [31:0] q;
    av(1'b1, 3'h1, {16'h0, ad}, q);
    av(1'b1, 3'h2, {24'h0, v}, q);
    av(1'b1, 3'h0, 32'h2, q);
    idle();
  endtask : prog
  task setup(input logic [15:0] ad, input logic [7:0] c);
    step();
    wreg(3'h1, 8'ha5);
    if (c != 8'ha1) wreg(3'h0, c);
    wreg(3'h2, ad[15:8]);
    wreg(3'h3, {ad[7], seed[6:0]});
    if (c == 8'ha1) wreg(3'h0, c);
    idle();
  endtask : setup
  task peek(input logic [15:0] ad, output logic [7:0] v);
    @(posedge sys_clk);
    readAddr <= ad;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    v = readData;
  endtask : peek
  task optRst(input logic [7:0] o);
    @(posedge sys_clk);
    optionByte <= o;
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : optRst
  task tool(input logic e, input logic [15:0] ad, input logic [7:0] v);
    @(posedge sys_clk);
    toolErase <= e;
    toolWrite <= !e;
    toolAddr <= ad;
    toolData <= v;
    @(posedge sys_clk);
    toolErase <= 1'b0;
    toolWrite <= 1'b0;
    idle();
  endtask : tool
  task mode(input logic m);
    @(posedge sys_clk);
    toolMode <= m;
  endtask : mode
  initial begin
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      step();
      optRst({i[2:0], seed[4:3], i[3], seed[1:0]});
      `CHK(resetVector, vecExp(optionByte))
    end
    optRst(8'hff);
    mode(1'b1);
    tool(1'b1, 16'h0, 8'h0);
    tool(1'b0, 16'h0b00, 8'h3a);
    mode(1'b0);
    setup(16'h0a80, 8'ha1);
    rreg(3'h0, d);
    `CHK(d[0], 1'b0)
    peek(16'h0b00, old);
    setup(16'h0a80, {7'h28, seed[7]});
    for (int j = 0; j < 3; j++) begin
      step();
      a = 16'h0a80 + ((j == 0) ? 16'h0 : (j == 1) ? 16'h7f : {10'h0, seed[5:0]} + 16'h1);
      prog(a, seed[15:8]);
      peek(a, d);
      `CHK(d, seed[15:8])
    end
    rc = rejCnt;
    prog(16'h0b00, 8'h00);
    `CHK(rejCnt - rc, 1)
    peek(16'h0b00, d);
    `CHK(d, old)
    wreg(3'h1, 8'h00);
    setup(16'h0a80, 8'ha1);
    wreg(3'h1, 8'h00);
    peek(16'h0aff, d);
    `CHK(d, 8'hff)
    peek(16'h0b00, d);
    `CHK(d, old)
    for (int s = 0; s < 4; s++) begin
      optRst({6'h20, s[1:0]});
      a = 16'h00ff + (16'h0100 << s);
      setup(a & 16'hff80, 8'h50);
      peek(a, old);
      rc = rejCnt;
      prog(a, 8'h00);
      `CHK(rejCnt - rc, 1)
      peek(a, d);
      `CHK(d, old)
    end
    setup(16'h0900, 8'ha1);
    setup(16'h0900, 8'h50);
    prog(16'h0900, 8'h3c);
    peek(16'h0900, d);
    `CHK(d, 8'h3c)
    optRst(8'h03);
    mode(1'b1);
    tool(1'b1, 16'h0, 8'h0);
    tool(1'b0, 16'h0190, 8'h96);
    peek(16'h0190, d);
    `CHK(d, 8'h96)
    optRst(8'hff);
    setup(16'h0180, 8'ha1);
    peek(16'h0190, d);
    `CHK(d, 8'h96)
    mode(1'b0);
    setup(16'h0180, 8'ha1);
    peek(16'h0190, d);
    `CHK(d, 8'hff)
    setup(16'h0a80, 8'h50);
    prog(16'h0a80, 8'h5a);
    wreg(3'h1, 8'ha4);
    wreg(3'h0, 8'ha1);
    repeat (20) @(negedge sys_clk);
    `CHK(busy, 1'b0)
    peek(16'h0a80, d);
    `CHK(d, 8'h5a)
    rreg(3'h0, d);
    `CHK(d[0], 1'b1)
    close_out();
  end
endmodule : testbench
`default_nettype wire
